// ==== shared/prog_entry_pkg.sv ====
// constants for the flash programming mode entry block
package prog_entry_pkg;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLOCK_HZ = 40000000;
   // window after the last mode pulse that closes pulse counting
   localparam int PULSE_WINDOW_US = 1000;
   localparam int PULSE_WINDOW_CYC = PULSE_WINDOW_US * (CLOCK_HZ / 1000000);
   localparam logic [3:0] MAX_PULSES = 4'hB;
   localparam logic [3:0] UART_PULSES = 4'h0;
   // ----------------------------------------------------------------
   // baud rates and the reset command used to measure them
   // ----------------------------------------------------------------
   localparam logic [7:0] RESET_CMD = 8'h00;
   localparam logic [7:0] ACK_CODE = 8'h06;
   localparam logic [7:0] NAK_CODE = 8'h15;
   localparam int LOW_PCLK_HZ = 2500000;
   localparam int FASTEST_BPS = 153600;
   // bit period at the fastest rate, in clock cycles
   localparam int FASTEST_BIT_CYC = CLOCK_HZ / FASTEST_BPS;
   // bit period at the slowest rate (9600 bps), in clock cycles
   localparam int SLOWEST_BIT_CYC = CLOCK_HZ / 9600;
   localparam logic [15:0] BIT_CYC_MIN = 16'(FASTEST_BIT_CYC - 40);
   localparam logic [15:0] BIT_CYC_MAX = 16'(SLOWEST_BIT_CYC + 400);
   localparam logic [15:0] FAST_LIMIT = 16'(FASTEST_BIT_CYC + 40);
   // ----------------------------------------------------------------
   // link states
   // ----------------------------------------------------------------
   typedef enum logic [5:0] {
      ST_IDLE   = 6'b000001,
      ST_COUNT  = 6'b000010,
      ST_CAL    = 6'b000100,
      ST_READY  = 6'b001000,
      ST_NORMAL = 6'b010000,
      ST_FAULT  = 6'b100000
   } entry_state_t;
endpackage : prog_entry_pkg

// ==== rtl/pin_sync.sv ====
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
   input  wire logic clock,
   input  wire logic reset,
   input  wire logic pin,
   output logic      level
);
   logic [2:0] sync_reg;
   logic [2:0] sync_next;
   logic       level_reg;
   logic       level_next;

   always_comb begin
      sync_next = {sync_reg[1:0], pin};
      // first stage is read only by the second
      level_next = (sync_reg[2] == sync_reg[1]) ? sync_reg[1] : level_reg;
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         sync_reg  <= 3'h0;
         level_reg <= 1'b0;
      end else begin
         sync_reg  <= sync_next;
         level_reg <= level_next;
      end
   end

   assign level = level_reg;
endmodule : pin_sync
`default_nettype wire

// ==== rtl/flash_prog_mode_entry.sv ====
// mode entry, pulse count and baud calibration for flash programming
//
// Operation
// R01 - primary pin low: normal mode, aux ignored
// R02 - primary high at release enters programming
// R03 - host never drives both mode pins high
// R04 - unused pins keep post-reset state
// R05 - count up to 11 primary pin pulses
// R06 - uart rates 9600 to 153600 bps
// R07 - 153600 refused when peripheral clock slow
// R08 - measure rx clock from first reset command
// R09 - only programmer drives reset in this mode
// R10 - programmer supplies clock on internal oscillator
// R11 - every command answered with ack or nak
// R12 - latch mode when count window closes
`timescale 1ns/1ps
`default_nettype none
module flash_prog_mode_entry
   import prog_entry_pkg::*;
#(
   parameter int WINDOW_CYC = PULSE_WINDOW_CYC
) (
   input  wire logic        clock,
   input  wire logic        reset,
   input  wire logic        prog_mode_primary_pin,
   input  wire logic        prog_mode_aux_pin,
   input  wire logic        boot_uart_rx_pin,
   input  wire logic        periph_clk_slow,
   input  wire logic        cmd_done,
   input  wire logic        cmd_valid_ok,
   output logic             boot_uart_tx_pin,
   output logic             port_config_hold,
   output logic             prog_mode,
   output logic             normal_mode,
   output logic             mode_fault,
   output logic [3:0]       comm_mode,
   output logic             link_ready,
   output logic [15:0]      bit_period
);
   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic primary_s;
   logic aux_s;
   logic rx_s;

   pin_sync u_sync_primary (
      .clock (clock),
      .reset (reset),
      .pin   (prog_mode_primary_pin),
      .level (primary_s)
   );
   pin_sync u_sync_aux (
      .clock (clock),
      .reset (reset),
      .pin   (prog_mode_aux_pin),
      .level (aux_s)
   );
   pin_sync u_sync_rx (
      .clock (clock),
      .reset (reset),
      .pin   (boot_uart_rx_pin),
      .level (rx_s)
   );

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   entry_state_t state_reg;
   entry_state_t state_next;
   logic [3:0]   pulse_reg;
   logic [3:0]   pulse_next;
   logic [3:0]   mode_reg;
   logic [3:0]   mode_next;
   logic [31:0]  win_reg;
   logic [31:0]  win_next;
   logic [7:0]   settle_reg;
   logic [7:0]   settle_next;
   logic         prim_d_reg;
   logic         rx_d_reg;
   logic [15:0]  meas_reg;
   logic [15:0]  meas_next;
   logic         meas_on_reg;
   logic         meas_on_next;
   logic [15:0]  period_reg;
   logic [15:0]  period_next;
   logic         tx_reg;
   logic         tx_next;
   logic [9:0]   tx_sh_reg;
   logic [9:0]   tx_sh_next;
   logic [3:0]   tx_cnt_reg;
   logic [3:0]   tx_cnt_next;
   logic [15:0]  tx_tim_reg;
   logic [15:0]  tx_tim_next;
   logic         settled;
   logic         prim_fall;
   logic         rx_fall;
   logic         rx_rise;

   // synchronisers need a few cycles before their level means anything
   assign settled   = (settle_reg == 8'h10);
   assign prim_fall = prim_d_reg & ~primary_s;
   assign rx_fall   = rx_d_reg & ~rx_s;
   assign rx_rise   = ~rx_d_reg & rx_s;

   always_comb begin
      state_next   = state_reg;
      pulse_next   = pulse_reg;
      mode_next    = mode_reg;
      win_next     = win_reg;
      settle_next  = settled ? settle_reg : settle_reg + 8'h01;
      meas_next    = meas_reg;
      meas_on_next = meas_on_reg;
      period_next  = period_reg;
      unique case (state_reg)
         ST_IDLE: begin
            if (settled) begin
               if (!primary_s) begin
                  state_next = ST_NORMAL;            // [R01]
               end else if (aux_s) begin
                  state_next = ST_FAULT;             // [R03]
               end else begin
                  state_next = ST_COUNT;             // [R02]
               end
            end
         end
         ST_COUNT: begin
            if (prim_fall) begin
               win_next = 32'h0;
               if (pulse_reg != MAX_PULSES) begin
                  pulse_next = pulse_reg + 4'h1;     // [R05]
               end
            end else if (win_reg == 32'(WINDOW_CYC - 1)) begin
               mode_next  = pulse_reg;               // [R12]
               state_next = ST_CAL;
            end else begin
               win_next = win_reg + 32'h1;
            end
         end
         ST_CAL: begin
            // reset command byte: start bit plus zero data bits form one
            // low span of nine bit times, so one rise ends the measurement
            if (mode_reg != UART_PULSES) begin
               state_next = ST_FAULT;
            end else if (!meas_on_reg) begin
               if (rx_fall) begin
                  meas_on_next = 1'b1;
                  // the fall cycle is the first low cycle of the span
                  meas_next    = 16'h1;
               end
            end else if (rx_rise) begin
               meas_on_next = 1'b0;
               if ((meas_reg / 16'h9) >= BIT_CYC_MIN &&
                   (meas_reg / 16'h9) <= BIT_CYC_MAX &&
                   !(periph_clk_slow &&
                     (meas_reg / 16'h9) < FAST_LIMIT)) begin // [R06] [R07]
                  period_next = meas_reg / 16'h9;    // [R08]
                  state_next  = ST_READY;
               end
            end else if (meas_reg != 16'hFFFF) begin
               meas_next = meas_reg + 16'h1;
            end
         end
         ST_READY: begin
         end
         ST_NORMAL: begin
         end
         ST_FAULT: begin
         end
      endcase
   end

   // answer transmitter, 8n1 at the calibrated period
   always_comb begin
      tx_sh_next  = tx_sh_reg;
      tx_cnt_next = tx_cnt_reg;
      tx_tim_next = tx_tim_reg;
      tx_next     = tx_reg;
      if (tx_cnt_reg == 4'h0) begin
         tx_next = 1'b1;
         if (state_reg == ST_READY && cmd_done) begin
            tx_sh_next  = {1'b1, cmd_valid_ok ? ACK_CODE : NAK_CODE,
                           1'b0};                    // [R11]
            // one count past the stop bit keeps it high a full period
            tx_cnt_next = 4'hB;
            tx_tim_next = 16'h0;
         end
      end else if (tx_tim_reg == 16'h0) begin
         tx_next     = tx_sh_reg[0];
         tx_sh_next  = {1'b1, tx_sh_reg[9:1]};
         tx_tim_next = period_reg - 16'h1;
         tx_cnt_next = tx_cnt_reg - 4'h1;
      end else begin
         tx_tim_next = tx_tim_reg - 16'h1;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state_reg   <= ST_IDLE;
         pulse_reg   <= 4'h0;
         mode_reg    <= 4'h0;
         win_reg     <= 32'h0;
         settle_reg  <= 8'h0;
         prim_d_reg  <= 1'b0;
         rx_d_reg    <= 1'b0;
         meas_reg    <= 16'h0;
         meas_on_reg <= 1'b0;
         period_reg  <= 16'h0;
         tx_reg      <= 1'b1;
         tx_sh_reg   <= 10'h3FF;
         tx_cnt_reg  <= 4'h0;
         tx_tim_reg  <= 16'h0;
      end else begin
         state_reg   <= state_next;
         pulse_reg   <= pulse_next;
         mode_reg    <= mode_next;
         win_reg     <= win_next;
         settle_reg  <= settle_next;
         prim_d_reg  <= primary_s;
         rx_d_reg    <= rx_s;
         meas_reg    <= meas_next;
         meas_on_reg <= meas_on_next;
         period_reg  <= period_next;
         tx_reg      <= tx_next;
         tx_sh_reg   <= tx_sh_next;
         tx_cnt_reg  <= tx_cnt_next;
         tx_tim_reg  <= tx_tim_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign boot_uart_tx_pin = tx_reg;
   // ports stay in reset state unless normal operation was chosen
   assign port_config_hold = (state_reg != ST_NORMAL);        // [R04]
   assign prog_mode   = (state_reg == ST_COUNT) || (state_reg == ST_CAL) ||
                        (state_reg == ST_READY);
   assign normal_mode = (state_reg == ST_NORMAL);
   assign mode_fault  = (state_reg == ST_FAULT);
   assign comm_mode   = mode_reg;
   assign link_ready  = (state_reg == ST_READY);
   assign bit_period  = period_reg;
endmodule : flash_prog_mode_entry
`default_nettype wire

// ==== verification/mode_entry_asserts.sv ====
// port assertions for the programming mode entry block
`timescale 1ns/1ps
`default_nettype none
module mode_entry_asserts
   import prog_entry_pkg::*;
#(
   parameter int WINDOW_CYC = PULSE_WINDOW_CYC
) (
   input wire logic        clock,
   input wire logic        reset,
   input wire logic        periph_clk_slow,
   input wire logic        boot_uart_tx_pin,
   input wire logic        port_config_hold,
   input wire logic        prog_mode,
   input wire logic        normal_mode,
   input wire logic        mode_fault,
   input wire logic [3:0]  comm_mode,
   input wire logic        link_ready,
   input wire logic [15:0] bit_period
);
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   chk_hold_mode: assert property (port_config_hold != normal_mode)
      else $error("port hold wrong");
   chk_mode_excl: assert property (!(prog_mode && normal_mode))
      else $error("two modes at once");
   chk_norm_stands: assert property (normal_mode |=> normal_mode)
      else $error("normal mode lost");
   chk_fault_excl: assert property (mode_fault |-> !prog_mode)
      else $error("fault with programming");
   chk_ready_prog: assert property (link_ready |-> prog_mode)
      else $error("ready outside programming");
   chk_mode_held: assert property (link_ready |=> $stable(comm_mode))
      else $error("mode changed after latch");
   chk_mode_uart: assert property (
      $rose(link_ready) |-> comm_mode == UART_PULSES)
      else $error("ready without uart mode");
   chk_rate_slow: assert property (
      $rose(link_ready) && periph_clk_slow |-> bit_period >= FAST_LIMIT)
      else $error("fast rate on slow clock");
   chk_tx_idle: assert property (!link_ready |-> boot_uart_tx_pin)
      else $error("tx active before ready");
endmodule : mode_entry_asserts
bind flash_prog_mode_entry mode_entry_asserts #(.WINDOW_CYC(WINDOW_CYC)) u_chk (
   .clock(clock), .reset(reset), .periph_clk_slow(periph_clk_slow),
   .boot_uart_tx_pin(boot_uart_tx_pin), .port_config_hold(port_config_hold),
   .prog_mode(prog_mode), .normal_mode(normal_mode), .mode_fault(mode_fault),
   .comm_mode(comm_mode), .link_ready(link_ready), .bit_period(bit_period));
`default_nettype wire

// ==== verification/prog_host.sv ====
// programmer model: mode pins and uart line into the device
`timescale 1ns/1ps
`default_nettype none
module prog_host (
   input  wire logic clock,
   output logic      primary,
   output logic      aux,
   output logic      rx
);
   initial begin
      primary = 1'b0;
      aux = 1'b0;
      rx = 1'b1;
   end
   // pins set while reset is held, so they are steady at release
   task automatic mode(input logic p, input logic a);
      primary <= p;
      aux <= a;
   endtask : mode
   // wide pulses so the pin filter cannot swallow them
   task automatic pulse();
      repeat (20) @(posedge clock);
      primary <= 1'b0;
      repeat (20) @(posedge clock);
      primary <= 1'b1;
   endtask : pulse
   // 8n1, lsb first; line returns to its pulled-up idle level
   task automatic send(input int bc, input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge clock);
         rx <= f[i];
         repeat (bc - 1) @(posedge clock);
      end
   endtask : send
endmodule : prog_host
`default_nettype wire

// ==== verification/flash_prog_mode_entry_bench.sv ====
// self-checking bench for the programming mode entry block
`timescale 1ns/1ps
`default_nettype none
module flash_prog_mode_entry_bench;
   import prog_entry_pkg::*;
   localparam int WIN = 200;
   localparam int BC = CLOCK_HZ / 76800;
   logic        clock, reset, slow, done, ok, tx, hold;
   logic        prog, norm, fault, ready, primary, aux, rx;
   logic [3:0]  mode;
   logic [15:0] bp;
   int          err_total, compares, cyc;
   prog_host i_host (.clock(clock), .primary(primary), .aux(aux), .rx(rx));
   flash_prog_mode_entry #(.WINDOW_CYC(WIN)) i_dut (
      .clock(clock), .reset(reset), .prog_mode_primary_pin(primary),
      .prog_mode_aux_pin(aux), .boot_uart_rx_pin(rx), .periph_clk_slow(slow),
      .cmd_done(done), .cmd_valid_ok(ok), .boot_uart_tx_pin(tx),
      .port_config_hold(hold), .prog_mode(prog), .normal_mode(norm),
      .mode_fault(fault), .comm_mode(mode), .link_ready(ready),
      .bit_period(bp));
   task automatic check(input logic [15:0] got, exp, input string m);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask : check
   task automatic print_verdict();
      $display("compares %0d, errors %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : print_verdict
   // reset values are looked at on every restart, while still in reset
   task automatic restart(input logic p, input logic a);
      @(posedge clock);
      reset <= 1'b1;
      i_host.mode(p, a);
      repeat (16) @(posedge clock);
      check(16'({tx, hold, prog, norm, fault}), 16'h18, "reset outputs");
      check(bp | 16'(mode), 16'h0, "reset values");
      reset <= 1'b0;
      repeat (30) @(negedge clock);
   endtask : restart
   // one answer byte, sampled mid-bit at the calibrated rate
   task automatic answer(input logic v, input logic [7:0] exp);
      logic [7:0] b;
      repeat (BC) @(posedge clock);
      done <= 1'b1;
      ok <= v;
      @(posedge clock);
      done <= 1'b0;
      for (int i = 0; i < 20 && tx; i++) @(negedge clock);
      repeat (BC / 2) @(negedge clock);
      check(16'(tx), 16'h0, "start bit");
      for (int i = 0; i < 8; i++) begin
         repeat (BC) @(negedge clock);
         b[i] = tx;
      end
      repeat (BC) @(negedge clock);
      check(16'({tx, b}), 16'({1'b1, exp}), "answer frame");
   endtask : answer
   task automatic t_normal();
      restart(1'b0, 1'b1);
      check(16'({norm, prog, fault, hold}), 16'h8, "normal mode");
   endtask : t_normal
   task automatic t_both_high();
      restart(1'b1, 1'b1);
      check(16'({fault, prog, norm}), 16'h4, "prohibited pins");
   endtask : t_both_high
   task automatic t_pulses();
      restart(1'b1, 1'b0);
      repeat (12) i_host.pulse();
      repeat (WIN + 20) @(negedge clock);
      check(16'({fault, mode}), 16'h1B, "saturated count");
   endtask : t_pulses
   task automatic t_uart();
      restart(1'b1, 1'b0);
      check(16'({prog, hold}), 16'h3, "programming entry");
      repeat (WIN + 20) @(negedge clock);
      check(16'({fault, mode}), 16'h0, "uart mode");
      @(posedge clock);
      slow <= 1'b1;
      i_host.send(FASTEST_BIT_CYC, RESET_CMD);
      @(negedge clock);
      check(16'(ready), 16'h0, "fast rate on slow clock");
      i_host.send(BC, RESET_CMD);
      @(negedge clock);
      check(16'(ready), 16'h1, "link ready");
      check(bp, 16'(BC), "measured period");
      answer(1'b1, ACK_CODE);
      answer(1'b0, NAK_CODE);
   endtask : t_uart
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   // ceiling well above the expected run of some 20000 cycles
   always @(posedge clock) begin
      cyc++;
      if (cyc == 60000) begin
         err_total++;
         print_verdict();
      end
   end
   initial begin
      reset = 1'b1;
      slow = 1'b0;
      done = 1'b0;
      ok = 1'b0;
      t_normal();
      t_both_high();
      t_pulses();
      t_uart();
      print_verdict();
   end
endmodule : flash_prog_mode_entry_bench
`default_nettype wire
